// ==== include/hpf_defs.svh ====
/*
 * offsets, field positions, reset values and timing counts of the host mac
 * pause and flow-control block.
 * assumes: included by bare name from the package and the design modules.
 */
`ifndef HPF_DEFS_SVH
`define HPF_DEFS_SVH

// register map, byte addresses inside the slave window
`define HPF_ADDR_W          8
`define HPF_FLOW_CTRL_ADDR  8'h20

// flow-control register fields
`define HPF_PT_MSB          31
`define HPF_PT_LSB          16
`define HPF_PASS_BIT        2
`define HPF_FCE_BIT         1
`define HPF_BUSY_BIT        0
`define HPF_PT_RESET        16'h0000

// ahb-lite encodings
`define HPF_HTRANS_NONSEQ   2'h2
`define HPF_HRESP_OKAY      1'h0

// slot time: 512 bit times, 4 bits per clock on a nibble-wide link
`define HPF_SLOT_BITS       512
`define HPF_BITS_PER_CLK    4
`define HPF_SLOT_CYCLES     (`HPF_SLOT_BITS / `HPF_BITS_PER_CLK)
`define HPF_SLOT_CNT_W      8
`define HPF_QUANTA_W        16

`endif

// ==== include/hpf_pkg.sv ====
/*
 * types of the host mac pause and flow-control block.
 * assumes: hpf_defs.svh is on the include path.
 */
`include "hpf_defs.svh"

package hpf_pkg;

    typedef enum logic [1:0] {
        HPF_TX_IDLE = 2'b01,
        HPF_TX_SEND = 2'b10
    } hpf_tx_state_t;

    typedef struct packed {
        logic [`HPF_SLOT_CNT_W-1:0] slot_cnt;
        logic [`HPF_QUANTA_W-1:0]   quanta_cnt;
        logic                       active;
    } hpf_timer_state_t;

    typedef struct packed {
        hpf_tx_state_t              tx_state;
        logic [`HPF_QUANTA_W-1:0]   pause_time;
        logic                       pass_ctrl;
        logic                       fce;
        logic                       busy;
        logic                       backpressure;
        logic                       dp_valid;
        logic                       dp_write;
        logic [`HPF_ADDR_W-1:0]     dp_addr;
        logic [31:0]                hrdata;
        logic                       pause_tx_req;
        logic [`HPF_QUANTA_W-1:0]   pause_tx_time;
        logic                       rx_out_valid;
        logic [7:0]                 rx_out_data;
        logic                       rx_out_last;
        logic                       rx_status_valid;
        logic                       rx_status_filter;
    } hpf_state_t;

endpackage

// ==== rtl/hpf_flow_ctrl.sv ====
/*
 * host mac flow control: pause-frame request, received pause decode,
 * transmitter hold, half-duplex backpressure and receive packet-filter status,
 * with the flow-control register reached over ahb-lite.
 * assumes: one clock; the receive parser and switch fabric port run on hclk,
 * so their signals need no synchroniser; one ahb-lite master.
 */
// Function
// - sent pause frames carry the upper 16 bits of the flow-control register
// - pass bit set and valid pause received sets the packet-filter status bit
// - pass bit clear leaves the packet-filter status bit cleared
// - every received frame's data goes to the application, status decides keep
// - promiscuous mode overrides the pass bit for packet-filter status
// - pause frames decoded and acted on only in full duplex with enable set
// - valid pause holds transmitter for decoded time times slot time
// - enable clear: no control-frame inspection, no transmitter pause
// - in half duplex the enable bit enables backpressure instead
// - software sets busy to send a pause; busy stays set while sending
// - busy clears itself when the pause frame has been sent
// - in half duplex bit 0 reads high while backpressure is applied
// - no pause frames and no backpressure while the transmitter is disabled
// - pause frames and backpressure go to the on-chip switch fabric port
`timescale 1ns/10ps
`include "hpf_defs.svh"

module hpf_flow_ctrl #(
    parameter logic [`HPF_SLOT_CNT_W-1:0] SLOT_CYCLES = `HPF_SLOT_CNT_W'(`HPF_SLOT_CYCLES)
) (
    // clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // ahb-lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic                     hready,
    input  wire logic [31:0]              hwdata,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    // mac mode
    input  wire logic                     full_duplex,
    input  wire logic                     tx_enable,
    input  wire logic                     promiscuous,
    // receive stream from the switch fabric
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_last,
    input  wire logic                     rx_is_pause,
    input  wire logic [`HPF_QUANTA_W-1:0] rx_pause_quanta,
    input  wire logic                     rx_addr_pass,
    input  wire logic                     rx_congested,
    // receive stream and status to the application
    output logic                          rx_out_valid,
    output logic [7:0]                    rx_out_data,
    output logic                          rx_out_last,
    output logic                          rx_status_valid,
    output logic                          rx_status_filter,
    // towards the switch fabric transmit side
    output logic                          pause_tx_req,
    output logic [`HPF_QUANTA_W-1:0]      pause_tx_time,
    input  wire logic                     pause_tx_done,
    output logic                          tx_hold,
    output logic                          backpressure
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    hpf_pkg::hpf_state_t st;
    hpf_pkg::hpf_state_t next_st;

    logic decode_en;
    logic pause_load;
    logic timer_active;
    logic addr_accept;
    logic wr_hit;

    function automatic logic flow_hit(input logic [`HPF_ADDR_W-1:0] a);
        flow_hit = (a == `HPF_FLOW_CTRL_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pause decode and transmitter hold

    assign decode_en  = full_duplex & st.fce;
    assign pause_load = rx_valid & rx_last & rx_is_pause & decode_en;

    hpf_pause_timer #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (pause_load),
        .quanta  (rx_pause_quanta),
        .clear   (~decode_en),
        .active  (timer_active)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    assign addr_accept = hsel & hready & (htrans == `HPF_HTRANS_NONSEQ);
    assign wr_hit      = st.dp_valid & st.dp_write & flow_hit(st.dp_addr);

    always_comb begin
        next_st = st;

        // bus address phase; the data phase follows with zero wait states
        next_st.dp_valid = addr_accept;
        if (addr_accept) begin
            next_st.dp_write = hwrite;
            next_st.dp_addr  = haddr[`HPF_ADDR_W-1:0];
            next_st.hrdata   = 32'h0000_0000;
            if (!hwrite && flow_hit(haddr[`HPF_ADDR_W-1:0])) begin
                next_st.hrdata[`HPF_PT_MSB:`HPF_PT_LSB] = st.pause_time;
                next_st.hrdata[`HPF_PASS_BIT]           = st.pass_ctrl;
                next_st.hrdata[`HPF_FCE_BIT]            = st.fce;
                // bit 0 means busy in full duplex, backpressure in half
                next_st.hrdata[`HPF_BUSY_BIT] = full_duplex ? st.busy
                                                            : st.backpressure;
            end
        end

        // pause-frame sequencer towards the fabric
        unique case (st.tx_state)
            hpf_pkg::HPF_TX_IDLE: begin
                if (st.busy && full_duplex && tx_enable) begin
                    next_st.tx_state      = hpf_pkg::HPF_TX_SEND;
                    next_st.pause_tx_req  = 1'b1;
                    next_st.pause_tx_time = st.pause_time;
                end
            end
            hpf_pkg::HPF_TX_SEND: begin
                if (pause_tx_done) begin
                    next_st.tx_state     = hpf_pkg::HPF_TX_IDLE;
                    next_st.pause_tx_req = 1'b0;
                    next_st.busy         = 1'b0;
                end else if (!tx_enable || !full_duplex) begin
                    // request is withdrawn; busy stays so it retries later
                    next_st.tx_state     = hpf_pkg::HPF_TX_IDLE;
                    next_st.pause_tx_req = 1'b0;
                end
            end
        endcase

        // register write; a one in bit 0 only ever sets busy
        if (wr_hit) begin
            next_st.pause_time = hwdata[`HPF_PT_MSB:`HPF_PT_LSB];
            next_st.pass_ctrl  = hwdata[`HPF_PASS_BIT];
            next_st.fce        = hwdata[`HPF_FCE_BIT];
            if (hwdata[`HPF_BUSY_BIT] && full_duplex) begin
                next_st.busy = 1'b1;
            end
        end

        // half-duplex backpressure, only with the transmitter running
        next_st.backpressure = ~full_duplex & st.fce & tx_enable & rx_congested;

        // every frame is passed on; the status tells the application what to do
        next_st.rx_out_valid = rx_valid;
        next_st.rx_out_data  = rx_data;
        next_st.rx_out_last  = rx_valid & rx_last;

        next_st.rx_status_valid = rx_valid & rx_last;
        if (rx_valid && rx_last) begin
            if (promiscuous) begin
                next_st.rx_status_filter = 1'b1;
            end else if (rx_is_pause && decode_en) begin
                next_st.rx_status_filter = st.pass_ctrl;
            end else begin
                next_st.rx_status_filter = rx_addr_pass;
            end
        end else begin
            next_st.rx_status_filter = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.tx_state <= hpf_pkg::HPF_TX_IDLE;
            st.pause_time <= `HPF_PT_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; the bus never waits and never errors

    assign hrdata           = st.hrdata;
    assign hreadyout        = 1'b1;
    assign hresp            = `HPF_HRESP_OKAY;
    assign rx_out_valid     = st.rx_out_valid;
    assign rx_out_data      = st.rx_out_data;
    assign rx_out_last      = st.rx_out_last;
    assign rx_status_valid  = st.rx_status_valid;
    assign rx_status_filter = st.rx_status_filter;
    assign pause_tx_req     = st.pause_tx_req;
    assign pause_tx_time    = st.pause_tx_time;
    assign tx_hold          = timer_active;
    assign backpressure     = st.backpressure;

endmodule

// ==== rtl/hpf_pause_timer.sv ====
/*
 * pause countdown: holds the transmitter for quanta times the slot time.
 * assumes: load is a one-cycle pulse, clear is a level that wins over all.
 */
`timescale 1ns/10ps
`include "hpf_defs.svh"

module hpf_pause_timer #(
    parameter logic [`HPF_SLOT_CNT_W-1:0] SLOT_CYCLES = `HPF_SLOT_CNT_W'(`HPF_SLOT_CYCLES)
) (
    // clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // control
    input  wire logic                     load,
    input  wire logic [`HPF_QUANTA_W-1:0] quanta,
    input  wire logic                     clear,
    // status
    output logic                          active
);

    hpf_pkg::hpf_timer_state_t st;
    hpf_pkg::hpf_timer_state_t next_st;

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.active = 1'b0;
        end else if (load) begin
            // a fresh frame restarts the count, even mid-pause
            next_st.active     = (quanta != '0);
            next_st.quanta_cnt = quanta;
            next_st.slot_cnt   = SLOT_CYCLES - 1'b1;
        end else if (st.active) begin
            if (st.slot_cnt == '0) begin
                next_st.slot_cnt = SLOT_CYCLES - 1'b1;
                if (st.quanta_cnt == `HPF_QUANTA_W'(1)) begin
                    next_st.active = 1'b0;
                end else begin
                    next_st.quanta_cnt = st.quanta_cnt - 1'b1;
                end
            end else begin
                next_st.slot_cnt = st.slot_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

endmodule

// ==== testbench/host_mac_pause_flow_control_bench.sv ====
/* bench for the flow-control block: registers, pause send, receive
 * status, pause hold and backpressure against a small model.
 * assumes: hpf_fabric_model answers pause requests. */
`timescale 1ns/10ps
module host_mac_pause_flow_control_bench;
    localparam int SLOT = 4;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, full_duplex, tx_enable;
    logic        promiscuous, rx_valid, rx_last, rx_is_pause, rx_addr_pass, rx_congested;
    logic        rx_out_valid, rx_out_last, rx_status_valid, rx_status_filter, tx_hold;
    logic        pause_tx_req, pause_tx_done, backpressure;
    logic [1:0]  htrans;
    logic [7:0]  rx_data, rx_out_data, delay;
    logic [15:0] rx_pause_quanta, pause_tx_time, sent_time;
    logic [31:0] haddr, hwdata, hrdata, rd, m_reg, seed;
    logic [7:0]  q_data[$];
    logic        q_filt[$];
    int          fail_count, samples_checked, rx_pos;
    hpf_flow_ctrl #(.SLOT_CYCLES(8'(SLOT))) u_dut (.hready(hreadyout), .hsize(3'h2), .*);
    hpf_fabric_model u_fabric (.*);
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // a wait that used up its bound counts as a mismatch and ends the run
    task automatic bound(input bit expired);
        if (expired) begin
            fail_count++;
            final_report();
        end
    endtask
    // address phase, then data phase; each waits for hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge hclk);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            bound(hreadyout !== 1'b1);
            htrans <= 2'h0;
            hwdata <= wd;
        end
        rd = hrdata;
        check("hresp", 32'(hresp), 32'h0);
    endtask
    task automatic wr(input logic [31:0] v);
        bus(1'b1, 8'h20, v);
        m_reg = v & 32'hFFFF_0006;
    endtask
    // three-byte frame; pause and filter results stand for the whole frame
    task automatic frame(input logic pz, input logic [15:0] q, input logic ap);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            seed = xs(seed);
            {rx_valid, rx_data, rx_last} <= {1'b1, seed[7:0], i == 2};
            {rx_is_pause, rx_pause_quanta, rx_addr_pass} <= {pz, q, ap};
            q_data.push_back(seed[7:0]);
        end
        q_filt.push_back(promiscuous ? 1'b1 : (pz && full_duplex && m_reg[1]) ? m_reg[2] : ap);
        @(posedge hclk);
        {rx_valid, rx_last, rx_data} <= {2'b00, ~seed[7:0]};
    endtask
    task automatic hold_chk(input int exp);
        int n;
        n = 0;
        repeat (exp + 6) begin
            @(posedge hclk);
            n += int'(tx_hold === 1'b1);
        end
        check("tx_hold cycles", 32'(n), 32'(exp));
    endtask
    always @(posedge hclk) begin
        if (rx_out_valid === 1'b1) begin
            check("rx_out_data", 32'(rx_out_data), 32'(q_data.pop_front()));
            check("rx_out_last", 32'(rx_out_last), 32'(rx_pos % 3 == 2));
            rx_pos++;
        end
        if (rx_status_valid === 1'b1)
            check("rx_status_filter", 32'(rx_status_filter), 32'(q_filt.pop_front()));
    end
    initial begin
        int n;
        {hresetn, hsel, hwrite, full_duplex, tx_enable, promiscuous} = 6'h16;
        {rx_valid, rx_last, rx_is_pause, rx_addr_pass, rx_congested} = 5'h00;
        {htrans, haddr, hwdata, rx_data, rx_pause_quanta} = 90'h0;
        {delay, seed, m_reg, fail_count, samples_checked, rx_pos} = {8'h09, 32'h0000_5470, 128'h0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h20, 32'h0);
        check("reset value", rd, 32'h0);
        bus(1'b0, 8'h24, 32'h0);
        check("unmapped read", rd, 32'h0);
        seed = xs(seed);
        wr({seed[31:16], 16'hFFF8});
        wr(m_reg | 32'h6);
        bus(1'b0, 8'h20, 32'h0);
        check("fields", rd, m_reg);
        $display("test registers done");
        for (int d = 9; d >= 0; d -= 9) begin
            delay <= 8'(d);
            seed = xs(seed);
            wr({seed[31:16], m_reg[15:0]});
            wr(m_reg | 32'h1);
            n = 0;
            do begin
                bus(1'b0, 8'h20, 32'h0);
                n++;
            end while (rd[0] !== 1'b0 && n < 20);
            bound(rd[0] !== 1'b0);
            if (d > 0)
                check("busy seen", 32'(n > 1), 32'h1);
            check("pause time sent", 32'(sent_time), 32'(m_reg[31:16]));
            check("busy cleared", rd, m_reg);
        end
        // a request made with the transmitter off waits until it is on again
        seed = xs(seed);
        wr({seed[31:16], m_reg[15:0]});
        tx_enable <= 1'b0;
        wr(m_reg | 32'h1);
        repeat (4) @(posedge hclk);
        check("no pause with tx off", 32'(pause_tx_req), 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        check("busy kept with tx off", 32'(rd[0]), 32'h1);
        tx_enable <= 1'b1;
        n = 0;
        do begin
            bus(1'b0, 8'h20, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        bound(rd[0] !== 1'b0);
        check("late pause time sent", 32'(sent_time), 32'(m_reg[31:16]));
        $display("test pause send done");
        for (int k = 0; k < 16; k++) begin
            promiscuous <= k[0];
            wr({m_reg[31:16], 13'h0000, k[3], 2'b10});
            frame(k[1], 16'h0000, k[2]);
        end
        repeat (3) @(posedge hclk);
        check("frames left", 32'(q_data.size() + q_filt.size()), 32'h0);
        $display("test receive done");
        frame(1'b1, 16'h0003, 1'b1);
        hold_chk(3 * SLOT);
        frame(1'b1, 16'h0005, 1'b1);
        repeat (4) @(posedge hclk);
        frame(1'b1, 16'h0002, 1'b1);
        hold_chk(2 * SLOT);
        wr(m_reg & ~32'h2);
        frame(1'b1, 16'h0003, 1'b1);
        hold_chk(0);
        full_duplex <= 1'b0;
        wr(m_reg | 32'h2);
        frame(1'b1, 16'h0003, 1'b1);
        hold_chk(0);
        $display("test pause hold done");
        rx_congested <= 1'b1;
        bus(1'b1, 8'h20, m_reg | 32'h1);
        repeat (2) @(posedge hclk);
        check("backpressure on", 32'(backpressure), 32'h1);
        check("no half duplex pause", 32'(pause_tx_req), 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        check("backpressure bit", rd, m_reg | 32'h1);
        tx_enable <= 1'b0;
        repeat (2) @(posedge hclk);
        check("backpressure off", 32'(backpressure), 32'h0);
        $display("test backpressure done");
        final_report();
    end
endmodule

// ==== testbench/hpf_fabric_model.sv ====
/* switch fabric transmit side: takes a pause request, reports it sent.
 * assumes: delay is steady while a request is pending. */
`timescale 1ns/10ps
module hpf_fabric_model (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // pause request from the mac
    input wire logic        pause_tx_req,
    input wire logic [15:0] pause_tx_time,
    input wire logic [7:0]  delay,
    output logic            pause_tx_done,
    output logic [15:0]     sent_time
);
    logic [7:0] wait_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 8'h00;
            pause_tx_done <= 1'b0;
            sent_time <= 16'h0000;
        end else if (pause_tx_req && !pause_tx_done && wait_cnt >= delay) begin
            pause_tx_done <= 1'b1;
            sent_time <= pause_tx_time;
            wait_cnt <= 8'h00;
        end else begin
            pause_tx_done <= 1'b0;
            wait_cnt <= pause_tx_req ? wait_cnt + 8'h01 : 8'h00;
        end
    end
endmodule

// ==== testbench/hpf_flow_checker.sv ====
/* assertions on the ports of the flow-control block: receive status,
 * pause hold, pause request and backpressure timing.
 * assumes: bound to hpf_flow_ctrl, one clock, hsel held high. */
`timescale 1ns/10ps
`include "hpf_defs.svh"
module hpf_flow_checker (
    // clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // mode and receive stream
    input wire logic        full_duplex,
    input wire logic        tx_enable,
    input wire logic        promiscuous,
    input wire logic        rx_valid,
    input wire logic        rx_last,
    input wire logic        rx_is_pause,
    input wire logic [15:0] rx_pause_quanta,
    input wire logic        rx_addr_pass,
    input wire logic        rx_congested,
    input wire logic        rx_out_valid,
    input wire logic        rx_status_valid,
    input wire logic        rx_status_filter,
    // transmit side
    input wire logic        pause_tx_req,
    input wire logic [15:0] pause_tx_time,
    input wire logic        pause_tx_done,
    input wire logic        tx_hold,
    input wire logic        backpressure
);
    // copy of the fields, taken at the write data edge like the register
    logic        wr_pend;
    logic        fce_sh;
    logic        pass_sh;
    logic [15:0] pt_sh;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            {pt_sh, pass_sh, fce_sh} <= 18'h00000;
        end else begin
            wr_pend <= hsel && hready && htrans == `HPF_HTRANS_NONSEQ && hwrite
                       && haddr[7:0] == `HPF_FLOW_CTRL_ADDR;
            if (wr_pend)
                {pt_sh, pass_sh, fce_sh} <= {hwdata[31:16], hwdata[2:1]};
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_pause_time: assert property ($rose(pause_tx_req) |-> pause_tx_time == pt_sh)
        else $error("pause frame time differs from register");
    a_filter_bit: assert property (
        rx_valid && rx_last |=> rx_status_valid && rx_status_filter == ($past(promiscuous)
        || ($past(rx_is_pause && full_duplex && fce_sh) ? $past(pass_sh)
        : $past(rx_addr_pass)))) else $error("receive filter bit wrong");
    a_filter_idle: assert property (!rx_status_valid |-> !rx_status_filter)
        else $error("filter bit without status");
    a_frame_copy: assert property (rx_valid |=> rx_out_valid)
        else $error("received byte not forwarded");
    a_hold_load: assert property (
        rx_valid && rx_last && rx_is_pause && full_duplex && fce_sh
        && rx_pause_quanta != 16'h0000 |-> ##[1:2] tx_hold) else $error("pause not held");
    a_hold_off: assert property (!fce_sh || !full_duplex |=> !tx_hold)
        else $error("transmitter held while disabled");
    a_bp_follow: assert property (1'b1 |=> backpressure ==
        $past(!full_duplex && fce_sh && tx_enable && rx_congested))
        else $error("backpressure level wrong");
    a_req_start: assert property (
        wr_pend && hwdata[0] && full_duplex && tx_enable && !pause_tx_req
        |=> ##1 pause_tx_req) else $error("pause request not started");
    a_req_drop: assert property (pause_tx_req && pause_tx_done |=> !pause_tx_req)
        else $error("pause request kept after done");
endmodule
bind hpf_flow_ctrl hpf_flow_checker u_chk (.*);
